// File: include/packet_params.svh
// numeric constants of the packet acknowledge and report engine
// assumes a 200 MHz core clock; included by the package and the engine
`ifndef PACKET_PARAMS_SVH
`define PACKET_PARAMS_SVH

`define CLK_MHZ 200
`define RESP_TIME_MS 250
`define FAN_PERIOD_MS 500
`define MS_CYCLES(ms) ((ms) * 1000 * `CLK_MHZ)

`define TYPE_PING 8'h00
`define TYPE_RESP 8'h40
`define TYPE_ERR 8'hc0
`define TYPE_KEY 8'h80
`define TYPE_FAN 8'h81
`define TYPE_TEMP 8'h82
`define TYPE_LOW_MSB 5

`define KEY_PRESS_BASE 8'h01
`define KEY_RELEASE_BASE 8'h07
`define KEY_COUNT 6
`define FAN_COUNT 4
`define TEMP_COUNT 16
`define REPORT_LEN 8'h04
`define KEY_LEN 8'h01
`define ERR_LEN 8'h00

`define CRC_INIT 16'hffff
`define CRC_POLY 16'h8408

`endif

// File: include/packet_pkg.sv
// types and the crc step shared by the engine
// relies on packet_params.svh for the crc constants
`include "packet_params.svh"

package packet_pkg;
	typedef enum logic [2:0] {R_TYPE, R_LEN, R_DATA, R_CRC0, R_CRC1} rx_state_e;
	typedef enum logic [2:0] {T_IDLE, T_TYPE, T_LEN, T_DATA, T_CRC0, T_CRC1} tx_state_e;
	typedef enum logic [2:0] {K_PING, K_ERR, K_KEY, K_FAN, K_TEMP} kind_e;

	// reflected crc-16, one byte per call
	function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] d);
		logic [15:0] c;
		c = crc ^ {8'h00, d};
		for (int i = 0; i < 8; i++) begin
			c = c[0] ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction
endpackage

// File: include/byte_link_if.sv
// byte stream with valid and ready between engine and output buffer
// assumes both ends share one clock
`timescale 1ns/1ps

interface byte_link_if;
	logic [7:0] data;
	logic valid;
	logic ready;
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface

// File: core/byte_skid_buffer.sv
// small in-order byte buffer; head entry drives the outputs directly
// assumes one clock; the consumer may hold out_ready low indefinitely
`timescale 1ns/1ps

module byte_skid_buffer #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	byte_link_if.snk in_link,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] slot;
		logic [CW-1:0] count;
		logic vld;
		logic rdy;
	} buf_s;

	buf_s st, next_st;
	logic pop, push;

	always_comb begin
		next_st = st;
		pop = st.vld && out_ready;
		push = in_link.valid && st.rdy;
		if (pop) begin
			for (int i = 0; i < DEPTH - 1; i++) begin
				next_st.slot[i] = st.slot[i + 1];
			end
			next_st.count = st.count - CW'(1);
		end
		if (push) begin
			next_st.slot[next_st.count] = in_link.data;
			next_st.count = next_st.count + CW'(1);
		end
		next_st.vld = next_st.count != '0;
		next_st.rdy = next_st.count != CW'(DEPTH);
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st <= '0;
			st.rdy <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign in_link.ready = st.rdy;
	assign out_data = st.slot[0];
	assign out_valid = st.vld;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	property p_stall_holds;
		out_valid && !out_ready |=> out_valid && $stable(out_data);
	endproperty
	a_stall_holds: assert property (p_stall_holds) else $error("buffer head changed during stall");

	property p_full_refuses;
		st.count == CW'(DEPTH) |-> !in_link.ready;
	endproperty
	a_full_refuses: assert property (p_full_refuses) else $error("buffer accepts while full");
endmodule

// File: core/packet_ack_and_report_engine.sv
// packet engine: checks received command packets, echoes ping, answers others, sends reports
// assumes byte-wide rx/tx streams from an 8n1 serializer or usb bridge, inputs synchronous
// Contract
// - every command packet is answered within 250 ms.
// - reports interleave with acknowledges; every packet is dispatched by type.
// - unsolicited reports typed 0x80 key, 0x81 fan, 0x82 temperature.
// - each enabled key press or release sends one-byte key report.
// - key presses code 1 to 6, releases 7 to 12, same key order.
// - each selected fan of four reports every half second.
// - fan report: index, tach cycle count, tick count high byte first.
// - each selected sensor of sixteen reports once per second.
// - temperature report: index, count low byte first, crc status.
// - answer type keeps the command type low six bits.
// - ping 0x00 echoed with same length and data as type 0x40.
// - packet is type, length, data, crc-16 low byte first.
// - serial link defaults to 115200 baud 8n1 on both sides.
`timescale 1ns/1ps
`include "packet_params.svh"

module packet_ack_and_report_engine import packet_pkg::*; #(
	parameter int unsigned RESP_CYCLES = `MS_CYCLES(`RESP_TIME_MS),
	parameter int unsigned HALF_CYCLES = `MS_CYCLES(`FAN_PERIOD_MS),
	parameter int FAN_N = `FAN_COUNT,
	parameter int TEMP_N = `TEMP_COUNT
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic [7:0] rx_data,
	input wire logic rx_valid,
	output logic [7:0] tx_data,
	output logic tx_valid,
	input wire logic tx_ready,
	input wire logic key_event,
	input wire logic [2:0] key_index,
	input wire logic key_pressed,
	input wire logic [5:0] key_press_mask,
	input wire logic [5:0] key_release_mask,
	input wire logic [FAN_N-1:0] fan_report_mask,
	input wire logic [FAN_N-1:0][7:0] tach_cycle_count,
	input wire logic [FAN_N-1:0][15:0] fan_timer_ticks,
	input wire logic [TEMP_N-1:0] temp_report_mask,
	input wire logic [TEMP_N-1:0][15:0] temp_counts,
	input wire logic [TEMP_N-1:0][7:0] temp_crc_status,
	output logic crc_drop
);
	typedef struct packed {
		rx_state_e rx_st;
		logic [7:0] rx_type;
		logic [7:0] rx_len;
		logic [7:0] rx_cnt;
		logic [15:0] rx_crc;
		logic [7:0] rx_crc_lo;
		logic ack_pend;
		logic [7:0] ack_type;
		logic [7:0] ack_len;
		logic [31:0] ack_age;
		logic key_pend;
		logic [7:0] key_code;
		logic [15:0] fan_pend;
		logic [15:0] temp_pend;
		logic [31:0] half_cnt;
		logic sec_phase;
		tx_state_e tx_st;
		kind_e kind;
		logic [7:0] tx_type;
		logic [7:0] tx_len;
		logic [7:0] tx_cnt;
		logic [15:0] tx_crc;
		logic [31:0] payload;
		logic crc_drop;
	} engine_s;

	engine_s st, next_st;
	logic [7:0] ping_mem [0:255];
	logic [7:0] out_byte;
	logic [15:0] crc_final;
	logic [3:0] idx;
	logic key_on, ack_set;
	byte_link_if link();
	function automatic logic [3:0] first_set(input logic [15:0] v);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 15; i >= 0; i--) begin
			if (v[i]) begin
				r = 4'(i);
			end
		end
		return r;
	endfunction

	assign crc_final = ~st.tx_crc;
	always_comb begin
		case (st.tx_st)
			T_TYPE: out_byte = st.tx_type;
			T_LEN: out_byte = st.tx_len;
			T_DATA: out_byte = (st.kind == K_PING) ? ping_mem[st.tx_cnt] : st.payload[31:24];
			T_CRC0: out_byte = crc_final[7:0];
			T_CRC1: out_byte = crc_final[15:8];
			default: out_byte = 8'h00;
		endcase
	end
	assign link.data = out_byte;
	assign link.valid = st.tx_st != T_IDLE;
	assign key_on = key_pressed ? key_press_mask[key_index] : key_release_mask[key_index];
	assign ack_set = rx_valid && st.rx_st == R_CRC1 && {rx_data, st.rx_crc_lo} == ~st.rx_crc;
	always_comb begin
		next_st = st;
		idx = 4'h0;
		next_st.crc_drop = 1'b0;
		// receive side
		if (rx_valid) begin
			case (st.rx_st)
				R_TYPE: begin
					next_st.rx_type = rx_data;
					next_st.rx_crc = crc_step(`CRC_INIT, rx_data);
					next_st.rx_st = R_LEN;
				end
				R_LEN: begin
					next_st.rx_len = rx_data;
					next_st.rx_cnt = 8'h00;
					next_st.rx_crc = crc_step(st.rx_crc, rx_data);
					next_st.rx_st = (rx_data == 8'h00) ? R_CRC0 : R_DATA;
				end
				R_DATA: begin
					next_st.rx_crc = crc_step(st.rx_crc, rx_data);
					next_st.rx_cnt = st.rx_cnt + 8'h01;
					if (st.rx_cnt == st.rx_len - 8'h01) begin
						next_st.rx_st = R_CRC0;
					end
				end
				R_CRC0: begin
					next_st.rx_crc_lo = rx_data;
					next_st.rx_st = R_CRC1;
				end
				default: begin
					next_st.rx_st = R_TYPE;
					if ({rx_data, st.rx_crc_lo} == ~st.rx_crc) begin
						if (st.rx_type == `TYPE_PING) begin
							next_st.ack_type = `TYPE_RESP;
							next_st.ack_len = st.rx_len;
						end else begin
							next_st.ack_type = `TYPE_ERR | {2'b00, st.rx_type[`TYPE_LOW_MSB:0]};
							next_st.ack_len = `ERR_LEN;
						end
					end else begin
						next_st.crc_drop = 1'b1;
					end
				end
			endcase
		end
		next_st.ack_age = st.ack_pend ? st.ack_age + 32'd1 : 32'd0;
		// transmit side: acknowledge first, then reports
		if (st.tx_st == T_IDLE) begin
			next_st.tx_crc = `CRC_INIT;
			next_st.tx_st = T_TYPE;
			if (st.ack_pend) begin
				next_st.ack_pend = 1'b0;
				next_st.kind = (st.ack_type == `TYPE_RESP) ? K_PING : K_ERR;
				next_st.tx_type = st.ack_type;
				next_st.tx_len = st.ack_len;
			end else if (st.key_pend) begin
				next_st.key_pend = 1'b0;
				next_st.kind = K_KEY;
				next_st.tx_type = `TYPE_KEY;
				next_st.tx_len = `KEY_LEN;
				next_st.payload = {st.key_code, 24'h000000};
			end else if (st.fan_pend != 16'h0000) begin
				idx = first_set(st.fan_pend);
				next_st.fan_pend[idx] = 1'b0;
				next_st.kind = K_FAN;
				next_st.tx_type = `TYPE_FAN;
				next_st.tx_len = `REPORT_LEN;
				next_st.payload = {4'h0, idx, tach_cycle_count[idx[1:0]], fan_timer_ticks[idx[1:0]]};
			end else if (st.temp_pend != 16'h0000) begin
				idx = first_set(st.temp_pend);
				next_st.temp_pend[idx] = 1'b0;
				next_st.kind = K_TEMP;
				next_st.tx_type = `TYPE_TEMP;
				next_st.tx_len = `REPORT_LEN;
				next_st.payload = {4'h0, idx, temp_counts[idx][7:0], temp_counts[idx][15:8],
					temp_crc_status[idx]};
			end else begin
				next_st.tx_st = T_IDLE;
			end
		end else if (link.ready) begin
			next_st.tx_crc = crc_step(st.tx_crc, out_byte);
			case (st.tx_st)
				T_TYPE: next_st.tx_st = T_LEN;
				T_LEN: begin
					next_st.tx_cnt = 8'h00;
					next_st.tx_st = (st.tx_len == 8'h00) ? T_CRC0 : T_DATA;
				end
				T_DATA: begin
					next_st.tx_cnt = st.tx_cnt + 8'h01;
					next_st.payload = {st.payload[23:0], 8'h00};
					if (st.tx_cnt == st.tx_len - 8'h01) begin
						next_st.tx_st = T_CRC0;
					end
				end
				T_CRC0: begin
					next_st.tx_crc = st.tx_crc;
					next_st.tx_st = T_CRC1;
				end
				default: begin
					next_st.tx_crc = st.tx_crc;
					next_st.tx_st = T_IDLE;
				end
			endcase
		end
		// events set after the clears so a new event is never lost
		next_st.ack_pend = next_st.ack_pend | ack_set;
		if (key_event && key_on) begin
			next_st.key_pend = 1'b1;
			next_st.key_code = key_pressed ? `KEY_PRESS_BASE + {5'h00, key_index}
				: `KEY_RELEASE_BASE + {5'h00, key_index};
		end
		next_st.half_cnt = st.half_cnt + 32'd1;
		if (st.half_cnt == HALF_CYCLES - 1) begin
			next_st.half_cnt = 32'd0;
			next_st.sec_phase = ~st.sec_phase;
			next_st.fan_pend = next_st.fan_pend | 16'(fan_report_mask);
			if (st.sec_phase) begin
				next_st.temp_pend = next_st.temp_pend | 16'(temp_report_mask);
			end
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (rx_valid && st.rx_st == R_DATA) begin
			ping_mem[st.rx_cnt] <= rx_data;
		end
	end
	assign crc_drop = st.crc_drop;
	byte_skid_buffer #(.WIDTH(8), .DEPTH(2)) u_out_buf (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.in_link(link),
		.out_data(tx_data),
		.out_valid(tx_valid),
		.out_ready(tx_ready)
	);

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	property p_ack_deadline;
		st.ack_pend |-> st.ack_age < RESP_CYCLES;
	endproperty
	a_ack_deadline: assert property (p_ack_deadline) else $error("acknowledge not started in time");
	property p_low_bits;
		rx_valid && st.rx_st == R_CRC1 && {rx_data, st.rx_crc_lo} == ~st.rx_crc
			|=> st.ack_pend && st.ack_type[5:0] == $past(st.rx_type[5:0]);
	endproperty
	a_low_bits: assert property (p_low_bits) else $error("answer type low bits differ");
	property p_bad_crc_silent;
		rx_valid && st.rx_st == R_CRC1 && {rx_data, st.rx_crc_lo} != ~st.rx_crc && !st.ack_pend
			|=> !st.ack_pend && crc_drop && st.rx_st == R_TYPE;
	endproperty
	a_bad_crc_silent: assert property (p_bad_crc_silent) else $error("bad packet answered");
	property p_ping_echo;
		st.tx_st == T_TYPE && st.kind == K_PING |-> st.tx_type == `TYPE_RESP;
	endproperty
	a_ping_echo: assert property (p_ping_echo) else $error("ping echo type wrong");
	property p_err_type;
		st.tx_st == T_TYPE && st.kind == K_ERR |-> st.tx_type[7:6] == 2'b11 && st.tx_len == 8'h00;
	endproperty
	a_err_type: assert property (p_err_type) else $error("error answer type wrong");
	property p_key_code;
		key_event && key_on |=> st.key_pend && st.key_code >= 8'd1 && st.key_code <= 8'd12;
	endproperty
	a_key_code: assert property (p_key_code) else $error("key code out of range");
	property p_fan_tick;
		st.half_cnt == HALF_CYCLES - 1 |=> (st.fan_pend & 16'($past(fan_report_mask))) == 16'($past(fan_report_mask));
	endproperty
	a_fan_tick: assert property (p_fan_tick) else $error("fan report not scheduled");
	property p_report_len;
		st.tx_st == T_TYPE && (st.kind == K_FAN || st.kind == K_TEMP) |-> st.tx_len == 8'h04
			&& st.payload[31:28] == 4'h0 && st.tx_type[7] && st.tx_type[6:2] == 5'h00;
	endproperty
	a_report_len: assert property (p_report_len) else $error("report header wrong");
	property p_crc_order;
		st.tx_st == T_CRC0 && link.ready |=> st.tx_st == T_CRC1 && st.tx_crc == $past(st.tx_crc);
	endproperty
	a_crc_order: assert property (p_crc_order) else $error("crc bytes out of order");
endmodule

// File: tb/host_crc_pkg.sv
// crc helper of the host side of the bench
// no surroundings assumed
package host_crc_pkg;
	// reflected crc-16, init all ones, result complemented
	function automatic logic [15:0] crc_of(input logic [7:0] b[$]);
		logic [15:0] c;
		c = 16'hffff;
		foreach (b[i]) begin
			c = c ^ {8'h00, b[i]};
			for (int k = 0; k < 8; k++) begin
				c = c[0] ? ((c >> 1) ^ 16'h8408) : (c >> 1);
			end
		end
		return ~c;
	endfunction
endpackage

// File: tb/host_link_model.sv
// host model: drains the engine's byte stream and splits it into packets
// assumes one clock; stall holds tx_ready low
`timescale 1ns/1ps

module host_link_model import host_crc_pkg::*; (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic stall,
	output logic [7:0] pkt [0:7],
	output logic crc_ok,
	output logic [15:0] pkt_cnt
);
	logic [7:0] cur[$];
	assign tx_ready = !stall;
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cur = {};
			crc_ok <= 1'b0;
			pkt_cnt <= 16'h0000;
		end else if (tx_valid && tx_ready) begin
			cur.push_back(tx_data);
			if (cur.size() > 3 && cur.size() == cur[1] + 4) begin
				crc_ok <= crc_of(cur[0:$-2]) === {cur[$], cur[$-1]};
				for (int i = 0; i < 8; i++) begin
					pkt[i] <= (i < cur.size()) ? cur[i] : 8'h00;
				end
				// each packet is handed on and counted in pkt_cnt
				pkt_cnt <= pkt_cnt + 16'h0001;
				cur = {};
			end
		end
	end
endmodule

// File: tb/packet_ack_and_report_engine_bench.sv
// bench of the packet engine: key rows, echo, stall, bad crc, reports, answers
// assumes host_link_model on the transmit side; short counts for reports
`timescale 1ns/1ps

module packet_ack_and_report_engine_bench import host_crc_pkg::*;;
	logic ref_clk, arst_n, rx_valid, tx_valid, key_event, key_pressed, crc_drop, stall, tx_ready, crc_ok;
	logic [7:0] rx_data, tx_data;
	logic [2:0] key_index;
	logic [5:0] key_press_mask, key_release_mask;
	logic [3:0] fan_report_mask;
	logic [3:0][7:0] tach_cycle_count;
	logic [3:0][15:0] fan_timer_ticks;
	logic [15:0] temp_report_mask, pkt_cnt;
	logic [15:0][15:0] temp_counts;
	logic [15:0][7:0] temp_crc_status;
	logic [7:0] pkt [0:7];
	int n_mismatch, n_tests, cyc, drops, t0;
	bit f;
	// key rows: index, press flag, expected code
	logic [11:0] key_rows [0:11] = '{12'h101, 12'h302, 12'h503, 12'h704, 12'h905, 12'hb06,
		12'h007, 12'h208, 12'h409, 12'h60a, 12'h80b, 12'ha0c};
	packet_ack_and_report_engine #(.RESP_CYCLES(2000), .HALF_CYCLES(200)) i_packet_ack_and_report_engine (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.rx_data(rx_data),
		.rx_valid(rx_valid),
		.tx_data(tx_data),
		.tx_valid(tx_valid),
		.tx_ready(tx_ready),
		.key_event(key_event),
		.key_index(key_index),
		.key_pressed(key_pressed),
		.key_press_mask(key_press_mask),
		.key_release_mask(key_release_mask),
		.fan_report_mask(fan_report_mask),
		.tach_cycle_count(tach_cycle_count),
		.fan_timer_ticks(fan_timer_ticks),
		.temp_report_mask(temp_report_mask),
		.temp_counts(temp_counts),
		.temp_crc_status(temp_crc_status),
		.crc_drop(crc_drop)
	);
	host_link_model i_host_link_model (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.tx_data(tx_data),
		.tx_valid(tx_valid),
		.tx_ready(tx_ready),
		.stall(stall),
		.pkt(pkt),
		.crc_ok(crc_ok),
		.pkt_cnt(pkt_cnt)
	);
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc++;
		if (crc_drop === 1'b1) drops++;
		if (cyc == 40000) begin
			n_mismatch++;
			conclude();
		end
	end
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wait_type(input logic [7:0] t, input int lim, output bit found);
		logic [15:0] c0;
		found = 0;
		c0 = pkt_cnt;
		for (int i = 0; i < lim && !found; i++) begin
			@(posedge ref_clk);
			#1;
			if (pkt_cnt !== c0) begin
				c0 = pkt_cnt;
				found = pkt[0] === t;
			end
		end
	endtask
	task automatic expect_pkt(input logic [7:0] t, input int lim);
		bit fd;
		wait_type(t, lim, fd);
		chk("packet seen", 16'h1, {15'h0, fd});
		chk("packet crc", 16'h1, {15'h0, crc_ok});
	endtask
	task automatic send(input logic [7:0] b[$], input logic bad);
		logic [15:0] c;
		c = crc_of(b) ^ {15'h0, bad};
		b.push_back(c[7:0]);
		b.push_back(c[15:8]);
		foreach (b[i]) begin
			rx_data = b[i];
			rx_valid = 1'b1;
			@(posedge ref_clk);
			#1;
		end
		rx_valid = 1'b0;
	endtask
	task automatic key(input logic [2:0] idx, input logic pr);
		key_index = idx;
		key_pressed = pr;
		key_event = 1'b1;
		@(posedge ref_clk);
		#1;
		key_event = 1'b0;
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		logic [7:0] ty;
		{arst_n, rx_valid, rx_data, key_event, key_index, key_pressed, stall} = '0;
		{fan_report_mask, temp_report_mask, tach_cycle_count, fan_timer_ticks} = '0;
		{temp_counts, temp_crc_status} = '0;
		key_press_mask = 6'h3f;
		key_release_mask = 6'h3f;
		repeat (20) @(posedge ref_clk);
		chk("reset tx_valid", 16'h0, {15'h0, tx_valid});
		chk("reset crc_drop", 16'h0, {15'h0, crc_drop});
		#1 arst_n = 1'b1;
		$display("test reset done");
		for (int r = 0; r < 12; r++) begin
			key(key_rows[r][11:9], key_rows[r][8]);
			expect_pkt(8'h80, 60);
			chk("key len", 16'h1, {8'h0, pkt[1]});
			chk("key code", {8'h0, key_rows[r][7:0]}, {8'h0, pkt[2]});
		end
		$display("test key rows done");
		key_press_mask = 6'h37;
		key(3'h3, 1'b1);
		wait_type(8'h80, 60, f);
		chk("masked key", 16'h0, {15'h0, f});
		$display("test key mask done");
		stall = 1'b1;
		send({8'h00, 8'h03, 8'hde, 8'had, 8'h5a}, 1'b0);
		repeat (30) @(posedge ref_clk);
		#1;
		chk("stalled valid", 16'h1, {15'h0, tx_valid});
		stall = 1'b0;
		expect_pkt(8'h40, 2000);
		chk("echo len", 16'h3, {8'h0, pkt[1]});
		chk("echo data", 16'hdead, {pkt[2], pkt[3]});
		chk("echo tail", 16'h5a, {8'h0, pkt[4]});
		$display("test echo stall done");
		t0 = drops;
		send({8'h00, 8'h01, 8'h11}, 1'b1);
		wait_type(8'h40, 60, f);
		chk("bad crc answer", 16'h0, {15'h0, f});
		chk("crc drops", 16'h1, 16'(drops - t0));
		$display("test bad crc done");
		fan_report_mask = 4'h4;
		tach_cycle_count[2] = 8'h37;
		fan_timer_ticks[2] = 16'h1234;
		expect_pkt(8'h81, 600);
		t0 = cyc;
		chk("fan len idx", 16'h0402, {pkt[1], pkt[2]});
		chk("fan tach", 16'h37, {8'h0, pkt[3]});
		chk("fan ticks", 16'h1234, {pkt[4], pkt[5]});
		chk("fan speed valid", 16'h1, 16'(pkt[3] > 8'h03 && pkt[3] != 8'hff));
		expect_pkt(8'h81, 600);
		chk("fan period", 16'h1, 16'(cyc - t0 >= 192 && cyc - t0 <= 208));
		temp_report_mask = 16'h0020;
		temp_counts[5] = 16'hfe68;
		temp_crc_status[5] = 8'h01;
		expect_pkt(8'h82, 1000);
		t0 = cyc;
		chk("temp len idx", 16'h0405, {pkt[1], pkt[2]});
		chk("temp count", 16'h68fe, {pkt[3], pkt[4]});
		chk("temp status", 16'h01, {8'h0, pkt[5]});
		chk("temp signed count", 16'hfe68, {pkt[4], pkt[3]});
		expect_pkt(8'h82, 1000);
		chk("temp period", 16'h1, 16'(cyc - t0 >= 392 && cyc - t0 <= 408));
		$display("test reports done");
		// answers while fan reports keep interleaving
		for (int i = 0; i < 5; i++) begin
			ty = (i == 0) ? 8'h00 : (i == 1) ? 8'h01 : (i == 2) ? 8'h1c : (i == 3) ? 8'h3f : 8'h7e;
			send({ty, 8'h00}, 1'b0);
			expect_pkt(ty == 8'h00 ? 8'h40 : {2'b11, ty[5:0]}, 2000);
			chk("answer len", 16'h0, {8'h0, pkt[1]});
		end
		$display("test answers done");
		conclude();
	end
endmodule
